// ---- core/dsfr_receiver.sv ----
// Three-wire serial frame receiver with system clock hand-off
`timescale 1ns/1ns

// Overview of operation
// R1: Active-low frame select; falling edge wakes inputs and enables shifting.
// R2: A frame is the 24 serial clock falling edges after select goes low.
// R3: Select rising before the 24th falling edge discards the partial frame.
// R4: Received serial data is held in a 24-bit shift register.
// R5: Data input is sampled on serial clock falling edges.
// R6: Host keeps the serial clock at or below 50 MHz.
// R7: Reference pin is an input after reset; output only with internal ref.
// R8: On the 24th edge hand the word over once; ignore later edges.
module dsfr_receiver (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic                serial_clk,
  input  wire logic                frame_sel_n,
  input  wire logic                serial_din,
  input  wire logic                internal_ref_sel,
  input  wire logic                internal_ref_level,
  input  wire logic                shared_reference_pin_i,
  output logic                     shared_reference_pin_o,
  output logic                     shared_reference_pin_oe,
  output logic                     ext_ref_level,
  output dsfr_pkg::dsfr_word_t     rx_word,
  output dsfr_pkg::dsfr_event_t    rx_event
);
  import dsfr_pkg::*;

  // Link domain, clocked by the host's serial clock

  logic                  link_rst;
  logic                  last_edge;
  logic [CNT_W-1:0]      bit_cnt_r;
  logic [CNT_W-1:0]      bit_cnt_nxt;
  logic [FRAME_BITS-1:0] shift_r;
  logic [FRAME_BITS-1:0] shift_nxt;
  logic [FRAME_BITS-1:0] link_word_r;
  logic                  word_tog_r;
  logic                  shifting;

  // Select high holds the shifter in reset, so the serial clock may
  // stop between frames and every frame starts from a clean count.
  assign link_rst = sys_rst | frame_sel_n; // R1 R3

  // Only the first 24 edges, up to and including the 24th, shift in data
  assign shifting    = (bit_cnt_r < CNT_DONE); // R8
  assign shift_nxt   = {shift_r[FRAME_BITS-2:0], serial_din}; // R4
  assign bit_cnt_nxt = bit_cnt_r + 5'h01;

  // Final data edge of a frame that is still selected
  assign last_edge = !frame_sel_n && (bit_cnt_r == CNT_LAST); // R8

  // Edge counter, counts falling edges within the frame
  always_ff @(negedge serial_clk or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_r <= CNT_RST;
    end else if (shifting) begin
      bit_cnt_r <= bit_cnt_nxt; // R2
    end
  end

  // Shift register, sampled on the falling edge
  always_ff @(negedge serial_clk or posedge link_rst) begin
    if (link_rst) begin
      shift_r <= WORD_RST;
    end else if (shifting) begin
      shift_r <= shift_nxt; // R5 R4
    end
  end

  // Completed word; only sys_rst clears it, so an aborted frame that
  // follows cannot disturb a word still crossing to the system clock.
  always_ff @(negedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_word_r <= WORD_RST;
    end else if (last_edge) begin
      link_word_r <= shift_nxt; // R8 R2
    end
  end

  // Toggle marks one completed word; a partial frame never toggles
  always_ff @(negedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      word_tog_r <= 1'b0;
    end else if (last_edge) begin
      word_tog_r <= ~word_tog_r; // R8 R3
    end
  end

  // System domain, clocked by mclk

  logic       word_tog_s;
  logic       word_tog_d_r;
  logic       word_new;
  logic       sel_act_s;
  logic       sel_act_d_r;
  logic       sel_rise;
  logic       sel_fall;
  logic       got_word_r;
  logic       word_valid_r;
  logic       frame_abort_r;
  logic       frame_active_r;
  logic [FRAME_BITS-1:0] rx_word_r;
  logic       ref_pin_s;
  logic       ref_oe_r;
  logic       ref_out_r;
  logic       ext_ref_r;

  // Toggle crossing for the word event
  dsfr_sync2 #(
    .WIDTH (1)
  ) u_tog_sync (
    .clk      (mclk),
    .rst      (sys_rst),
    .async_in (word_tog_r),
    .sync_out (word_tog_s)
  );

  // Selected level into the system domain; idles low
  dsfr_sync2 #(
    .WIDTH (1)
  ) u_sel_sync (
    .clk      (mclk),
    .rst      (sys_rst),
    .async_in (~frame_sel_n),
    .sync_out (sel_act_s)
  );

  // Reference pin level, read back when used as an input
  dsfr_sync2 #(
    .WIDTH (1)
  ) u_ref_sync (
    .clk      (mclk),
    .rst      (sys_rst),
    .async_in (shared_reference_pin_i),
    .sync_out (ref_pin_s)
  );

  // Delayed copies for edge detection, taken after synchronisation
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      word_tog_d_r <= 1'b0;
      sel_act_d_r  <= 1'b0;
    end else begin
      word_tog_d_r <= word_tog_s;
      sel_act_d_r  <= sel_act_s;
    end
  end

  // Edges named after the pin; reset value matches idle, no false edge
  assign word_new = word_tog_s ^ word_tog_d_r;
  assign sel_fall = sel_act_s & ~sel_act_d_r;
  assign sel_rise = ~sel_act_s & sel_act_d_r;

  // Word capture; the link word is stable long before the next frame
  // can complete, so a toggle handshake suffices for the data.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_word_r    <= WORD_RST;
      word_valid_r <= 1'b0;
    end else begin
      word_valid_r <= word_new; // R8
      if (word_new) begin
        rx_word_r <= link_word_r; // R8
      end
    end
  end

  // Word seen in this frame; a new word wins over the clear at start
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      got_word_r <= 1'b0;
    end else if (word_new) begin
      got_word_r <= 1'b1;
    end else if (sel_fall) begin
      got_word_r <= 1'b0;
    end
  end

  // Abort when select rises with no complete word in the frame
  // A word landing in the same cycle as the rise wins, so no false abort
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_abort_r <= 1'b0;
    end else begin
      frame_abort_r <= sel_rise & ~got_word_r & ~word_new; // R3
    end
  end

  // Frame active flag, shows the input buffers awake
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_active_r <= 1'b0;
    end else begin
      frame_active_r <= sel_act_s; // R1
    end
  end

  // Reference pin: input by default, driven only with internal ref
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_oe_r  <= 1'b0;
      ref_out_r <= 1'b0;
      ext_ref_r <= 1'b0;
    end else begin
      ref_oe_r  <= internal_ref_sel; // R7
      ref_out_r <= internal_ref_level;
      ext_ref_r <= ref_pin_s & ~internal_ref_sel; // R7
    end
  end

  // Outputs, all from flip-flops
  assign shared_reference_pin_oe = ref_oe_r;
  assign shared_reference_pin_o  = ref_out_r;
  assign ext_ref_level           = ext_ref_r;
  assign rx_word.word            = rx_word_r;
  assign rx_event.word_valid     = word_valid_r;
  assign rx_event.frame_abort    = frame_abort_r;
  assign rx_event.frame_active   = frame_active_r;

endmodule

// ---- core/dsfr_pkg.sv ----
// Shared constants and carrier types for the serial frame receiver
package dsfr_pkg;

  // Frame geometry
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned CNT_W      = 5;
  localparam logic [CNT_W-1:0] CNT_RST  = 5'h00;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'(FRAME_BITS - 1);
  localparam logic [CNT_W-1:0] CNT_DONE = 5'(FRAME_BITS);

  // Reset values
  localparam logic [FRAME_BITS-1:0] WORD_RST = 24'h000000;

  // Clock rates, for reference by the bench
  localparam int unsigned MCLK_HZ     = 25_000_000;
  localparam int unsigned SCLK_MAX_HZ = 50_000_000;

  // Synchroniser depth
  localparam int unsigned SYNC_STAGES = 2;

  // Complete frame as handed to command decoding
  typedef struct packed {
    logic [FRAME_BITS-1:0] word;
  } dsfr_word_t;

  // Frame events seen in the system clock domain
  typedef struct packed {
    logic word_valid;
    logic frame_abort;
    logic frame_active;
  } dsfr_event_t;

endpackage

// ---- core/dsfr_sync2.sv ----
// Two flip-flop level synchroniser into a destination clock domain
`timescale 1ns/1ns
module dsfr_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ---- testbench/dsfr_assertions.sv ----
// Port checker for the serial frame receiver
`timescale 1ns/1ns
module dsfr_assertions (
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  input wire logic                  frame_sel_n,
  input wire logic                  internal_ref_sel,
  input wire logic                  internal_ref_level,
  input wire logic                  shared_reference_pin_o,
  input wire logic                  shared_reference_pin_oe,
  input wire logic                  ext_ref_level,
  input wire dsfr_pkg::dsfr_word_t  rx_word,
  input wire dsfr_pkg::dsfr_event_t rx_event
);
  import dsfr_pkg::*;
  // One domain only, so clock and reset are given once
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_oe_follows: assert property (shared_reference_pin_oe ==
    $past(internal_ref_sel)) else $error("pin enable lags select");
  a_drive_value: assert property (shared_reference_pin_o ==
    $past(internal_ref_level)) else $error("pin value wrong");
  a_ext_quiet: assert property (shared_reference_pin_oe [*3] |->
    !ext_ref_level) else $error("input level while driving");
  a_valid_pulse: assert property (rx_event.word_valid |=>
    !rx_event.word_valid) else $error("word pulse too long");
  a_word_holds: assert property (!rx_event.word_valid |->
    $stable(rx_word)) else $error("word moved without pulse");
  a_abort_idle: assert property (rx_event.frame_abort |->
    !rx_event.frame_active && !rx_event.word_valid)
    else $error("abort during frame or with word");
  a_active_on: assert property (!frame_sel_n [*4] |->
    rx_event.frame_active) else $error("frame not active");
  a_active_off: assert property (frame_sel_n [*4] |->
    !rx_event.frame_active) else $error("frame still active");
  c_word: cover property (rx_event.word_valid);
  c_abort: cover property (rx_event.frame_abort);
  c_drive: cover property (shared_reference_pin_oe);
  c_active: cover property (rx_event.frame_active);
endmodule

// ---- testbench/dsfr_host_model.sv ----
// Serial master that writes frames into the receiver
`timescale 1ns/1ns
module dsfr_host_model (
  output logic sclk,
  output logic sel_n,
  output logic din
);
  // Idle link: clock parked high, select high
  initial begin
    sclk = 1'b1;
    sel_n = 1'b1;
    din = 1'b0;
  end
  // Clock runs only inside frames; bits past the 24th are junk
  task automatic send(input int n, input logic [23:0] w);
    sel_n = 1'b0;
    #13;
    for (int i = 0; i < n; i++) begin
      din = i < 24 ? w[23 - i] : ~din;
      #10 sclk = 1'b0;
      #10 sclk = 1'b1;
    end
    #120 sel_n = 1'b1;
    din = ~din; // Released line must not look valid
    #200;
  endtask
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the serial frame receiver
`timescale 1ns/1ns
module tb_top;
  import dsfr_pkg::*;
  logic        mclk = 1'b0, sys_rst = 1'b1, sel = 1'b0, lvl = 1'b0;
  logic        ext = 1'b0, sclk, sel_n, din, pin_i, pin_o, pin_oe, ext_o;
  dsfr_word_t  rx_word;
  dsfr_event_t rx_event;
  logic [15:0] r = 16'hA8B6;
  logic [23:0] w, last = 24'h000000;
  int          error_cnt = 0, checks = 0, vcnt = 0, acnt = 0;
  int          n, ev = 0, ab = 0, L[5] = '{24, 26, 10, 23, 0};
  always #20 mclk = ~mclk;
  assign pin_i = pin_oe ? pin_o : ext; // Resolved pin level
  dsfr_host_model host (.sclk(sclk), .sel_n(sel_n), .din(din));
  dsfr_receiver uut (.mclk(mclk), .sys_rst(sys_rst), .serial_clk(sclk),
    .frame_sel_n(sel_n), .serial_din(din), .internal_ref_sel(sel),
    .internal_ref_level(lvl), .shared_reference_pin_i(pin_i),
    .shared_reference_pin_o(pin_o), .shared_reference_pin_oe(pin_oe),
    .ext_ref_level(ext_o), .rx_word(rx_word), .rx_event(rx_event));
  function automatic logic [15:0] lf(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Pin level reaches the core only while the pin is an input
  function automatic logic [23:0] exp_ext(logic s, logic e);
    return 24'(s ? 1'b0 : e);
  endfunction
  task automatic chk(string nm, logic [23:0] s, logic [23:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Tally pulses so a doubled or missing one is caught
  always @(posedge mclk) begin
    vcnt <= vcnt + int'(rx_event.word_valid === 1'b1);
    acnt <= acnt + int'(rx_event.frame_abort === 1'b1);
  end
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
  // Fixed length table first, then random frames
  initial begin
    repeat (20) @(posedge mclk);
    #2 sys_rst = 1'b0;
    chk("oe", 24'(pin_oe), 24'h000000);
    chk("word", rx_word.word, 24'h000000);
    for (int f = 0; f < 16; f++) begin
      @(posedge mclk);
      #2 r = lf(r);
      w = {r[7:0], lf(r)};
      r = lf(lf(r));
      n = f < 5 ? L[f] : r[15] ? 24 : int'(r[12:8]);
      sel = r[2];
      lvl = r[3];
      ext = r[4];
      repeat (5) @(posedge mclk);
      #2 chk("oe", 24'(pin_oe), 24'(sel));
      chk("o", 24'(pin_o), 24'(lvl));
      chk("ext", 24'(ext_o), exp_ext(sel, ext));
      host.send(n, w);
      repeat (8) @(posedge mclk);
      #2 ev += int'(n >= 24);
      ab += int'(n < 24);
      if (n >= 24) last = w;
      chk("valid", 24'(vcnt), 24'(ev));
      chk("abort", 24'(acnt), 24'(ab));
      chk("word", rx_word.word, last);
    end
    end_of_test();
  end
endmodule
bind dsfr_receiver dsfr_assertions chk_i (.mclk, .sys_rst, .frame_sel_n,
  .internal_ref_sel, .internal_ref_level, .shared_reference_pin_o,
  .shared_reference_pin_oe, .ext_ref_level, .rx_word, .rx_event);
